// ==== src/training_pattern_gain_regs.v ====
/*
  write-only register bank for the custom de-skew pattern and the
  decimator clipping gain control, with read-back images at odd offsets.
  the three stored bytes feed the serializer training word and the
  decimator gain selection, both registered one clock later.
  assumes a simple synchronous register port already decoded from the
  serial control interface, in the core_clk domain, with one strobe per
  access; the training select field and the built-in words come from
  decimator control logic outside this bank.
*/
`timescale 1ns/1ns
`include "training_pattern_gain_defines.vh"

module training_pattern_gain_regs
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  input  wire [1:0]  train_sel,
  input  wire [11:0] builtin_word,
  output reg  [7:0]  reg_rdata,
  output reg         reg_rvalid,
  output wire [11:0] train_word,
  output wire        auto_gain_active,
  output wire [2:0]  gain_a,
  output wire [2:0]  gain_b
);

  // one slot per write-only register, in offset order
  localparam NUM_SLOTS = 3;
  localparam SLOT_W    = 8;
  localparam SLOT_LOW  = 0;
  localparam SLOT_HIGH = 1;
  localparam SLOT_CLIP = 2;

  // slot storage, decode and field nets
  wire [23:0] store_flat;
  wire [2:0]  wr_hit;
  wire [2:0]  rb_hit;
  wire [7:0]  pat_low;
  wire [7:0]  pat_high;
  wire [7:0]  clip_val;
  wire [11:0] custom_word;
  wire        override_bit;
  wire [2:0]  coef_a;
  wire [2:0]  coef_b;
  reg  [7:0]  rdata_nxt;
  reg         auto_r;
  integer     k;

  // write offset of a slot
  function [7:0] slot_wr_addr;
    input integer idx;
    begin
      case (idx)
        SLOT_LOW:  slot_wr_addr = `ADDR_PAT_LOW;
        SLOT_HIGH: slot_wr_addr = `ADDR_PAT_HIGH;
        default:   slot_wr_addr = `ADDR_CLIP;
      endcase
    end
  endfunction

  // read-back offset of a slot, one above its write offset
  function [7:0] slot_rb_addr;
    input integer idx;
    begin
      case (idx)
        SLOT_LOW:  slot_rb_addr = `ADDR_PAT_LOW_RB;
        SLOT_HIGH: slot_rb_addr = `ADDR_PAT_HIGH_RB;
        default:   slot_rb_addr = `ADDR_CLIP_RB;
      endcase
    end
  endfunction

  // reset value of a slot
  function [7:0] slot_reset;
    input integer idx;
    begin
      case (idx)
        SLOT_LOW:  slot_reset = `RST_PAT_LOW;
        SLOT_HIGH: slot_reset = `RST_PAT_HIGH;
        default:   slot_reset = `RST_CLIP;
      endcase
    end
  endfunction

  // one address compare, shared by the write and read-back decode
  function addr_match;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // override bit of the clipping byte
  function clip_override;
    input [7:0] val;
    begin
      clip_override = val[`CLIP_OVERRIDE_BIT];
    end
  endfunction

  // coefficient a field of the clipping byte
  function [2:0] clip_coef_a;
    input [7:0] val;
    begin
      clip_coef_a = val[`CLIP_A_MSB:`CLIP_A_LSB];
    end
  endfunction

  // coefficient b field of the clipping byte
  function [2:0] clip_coef_b;
    input [7:0] val;
    begin
      clip_coef_b = val[`CLIP_B_MSB:`CLIP_B_LSB];
    end
  endfunction

  // storage slots; every bit kept as written, so a host that ignores the
  // write-zero advice on the high pattern byte still reads its value back
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g = g + 1)
    begin : slot
      reg [SLOT_W-1:0] val_r;

      // strobe qualified by this slot's write offset; other offsets ignored
      assign wr_hit[g] = reg_wr & addr_match(reg_addr, slot_wr_addr(g));
      // read-back hit; the write offset itself never matches here
      assign rb_hit[g] = addr_match(reg_addr, slot_rb_addr(g));

      // write-only byte, loaded on its own strobe
      always @(posedge core_clk or posedge rst)
      begin
        if (rst)
          val_r <= slot_reset(g); // RULE10
        else if (wr_hit[g])
          val_r <= reg_wdata; // RULE1 RULE2 RULE3
      end

      assign store_flat[SLOT_W*g +: SLOT_W] = val_r;
    end
  endgenerate

  // named views of the stored bytes
  assign pat_low      = store_flat[SLOT_W*SLOT_LOW +: SLOT_W];
  assign pat_high     = store_flat[SLOT_W*SLOT_HIGH +: SLOT_W];
  assign clip_val     = store_flat[SLOT_W*SLOT_CLIP +: SLOT_W];

  // clipping fields; override and coefficients travel together
  assign override_bit = clip_override(clip_val);
  assign coef_a       = clip_coef_a(clip_val);
  assign coef_b       = clip_coef_b(clip_val);

  // read-back decode: unmapped offsets and the write offsets read zero
  always @*
  begin
    rdata_nxt = 8'h00;
    for (k = 0; k < NUM_SLOTS; k = k + 1)
    begin
      if (rb_hit[k])
        rdata_nxt = store_flat[SLOT_W*k +: SLOT_W]; // RULE1 RULE2 RULE3
    end
  end

  // read data holds until the next read strobe;
  // a write alone never disturbs it
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt; // RULE1 RULE2 RULE3
  end

  // one-cycle answer strobe, one clock after the read strobe;
  // back-to-back reads give back-to-back strobes
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reg_rvalid <= 1'b0;
    else
      reg_rvalid <= reg_rd;
  end

  // flag follows the inverted override bit a clock late, in step with the
  // registered gain outputs so both change on the same edge
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
      auto_r <= 1'b1;
    else
      auto_r <= ~override_bit; // RULE9
  end

  // twelve-bit word: low nibble of the high byte over the low byte;
  // the upper four high-byte bits stay out of the word
  assign custom_word      = {pat_high[`PAT_HIGH_MSB:0], pat_low}; // RULE4 RULE5 RULE6
  assign auto_gain_active = auto_r;

  // word choice and gain selection live in one registered stage, so
  // every derived output lags its register by exactly one clock
  training_word_select u_sel
  (
    .core_clk             (core_clk),
    .rst                  (rst),
    .train_sel            (train_sel),
    .custom_word          (custom_word),
    .builtin_word         (builtin_word),
    .custom_gain_override (override_bit),
    .coef_a               (coef_a),
    .coef_b               (coef_b),
    .train_word           (train_word),
    .gain_a               (gain_a),
    .gain_b               (gain_b)
  );

endmodule

// ==== src/training_pattern_gain_defines.vh ====
/*
  register offsets, field positions and reset values for the training
  pattern and clipping gain register bank.
  assumes inclusion by bare name from the design files under src/.
*/
// Contract
// (RULE1) low pattern register is write-only; reading 0x11 returns its contents.
// (RULE2) high pattern register is write-only; reading 0x13 returns its contents.
// (RULE3) clipping control register is write-only; reading 0x15 returns its contents.
// (RULE4) both pattern registers combine into one 12-bit training word.
// (RULE5) low pattern byte forms training word bits 7:0.
// (RULE6) high pattern bits 3:0 form training word bits 11:8.
// (RULE7) host writes zeros into high pattern bits 7:4.
// (RULE8) custom word is sent only when training select equals three.
// (RULE9) override clear gives automatic gain; set uses coefficients a and b.
// (RULE10) registers reset to zero; override bit 7, a 5:3, b 2:0.
`ifndef TRAINING_PATTERN_GAIN_DEFINES_VH
`define TRAINING_PATTERN_GAIN_DEFINES_VH

`define ADDR_PAT_LOW       8'h10
`define ADDR_PAT_LOW_RB    8'h11
`define ADDR_PAT_HIGH      8'h12
`define ADDR_PAT_HIGH_RB   8'h13
`define ADDR_CLIP          8'h14
`define ADDR_CLIP_RB       8'h15

`define RST_PAT_LOW        8'h00
`define RST_PAT_HIGH       8'h00
`define RST_CLIP           8'h00

`define PAT_HIGH_MSB       3
`define CLIP_OVERRIDE_BIT  7
`define CLIP_A_MSB         5
`define CLIP_A_LSB         3
`define CLIP_B_MSB         2
`define CLIP_B_LSB         0

`define TRAIN_SEL_CUSTOM   2'h3
`define AUTO_GAIN_A        3'h0
`define AUTO_GAIN_B        3'h0

`endif

// ==== src/training_word_select.v ====
/*
  picks the serializer training word and the decimator gain coefficients.
  assumes its inputs are registered values in the core_clk domain.
*/
`timescale 1ns/1ns
`include "training_pattern_gain_defines.vh"

module training_word_select
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire [1:0]  train_sel,
  input  wire [11:0] custom_word,
  input  wire [11:0] builtin_word,
  input  wire        custom_gain_override,
  input  wire [2:0]  coef_a,
  input  wire [2:0]  coef_b,
  output reg  [11:0] train_word,
  output reg  [2:0]  gain_a,
  output reg  [2:0]  gain_b
);

  // registered so every top output comes straight from a flip-flop
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      train_word <= 12'h000;
      gain_a     <= 3'h0;
      gain_b     <= 3'h0;
    end
    else
    begin
      // custom word only for sequence three
      train_word <= (train_sel == `TRAIN_SEL_CUSTOM) ? custom_word : builtin_word; // RULE8
      // automatic coefficients unless software overrides
      gain_a <= custom_gain_override ? coef_a : `AUTO_GAIN_A; // RULE9
      gain_b <= custom_gain_override ? coef_b : `AUTO_GAIN_B; // RULE9
    end
  end

endmodule

// ==== verification/regs_checker.sv ====
/* port assertions for the pattern and clip gain bank.
   assumes a bind onto training_pattern_gain_regs. */
`timescale 1ns/1ns
module regs_checker (
  input logic        core_clk,
  input logic        rst,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic        reg_rvalid,
  input logic        auto_gain_active,
  input logic [7:0]  reg_addr,
  input logic [7:0]  reg_wdata,
  input logic [7:0]  reg_rdata,
  input logic [1:0]  train_sel,
  input logic [11:0] builtin_word,
  input logic [11:0] train_word,
  input logic [2:0]  gain_a,
  input logic [2:0]  gain_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
    else $error("rvalid not one cycle after read");
  low_readback_a: assert property (
    (reg_wr && reg_addr == 8'h10) ##1 (reg_rd && reg_addr == 8'h11)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad 11h");
  high_readback_a: assert property (
    (reg_wr && reg_addr == 8'h12) ##1 (reg_rd && reg_addr == 8'h13)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad 13h");
  clip_readback_a: assert property (
    (reg_wr && reg_addr == 8'h14) ##1 (reg_rd && reg_addr == 8'h15)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("bad 15h");
  word_low_a: assert property (
    (reg_wr && reg_addr == 8'h10) ##1 train_sel == 2'h3
    |=> train_word[7:0] == $past(reg_wdata, 2)) else $error("bad low word");
  word_high_a: assert property (
    (reg_wr && reg_addr == 8'h12) ##1 train_sel == 2'h3
    |=> train_word[11:8] == $past(reg_wdata[3:0], 2)) else $error("bad high word");
  builtin_pass_a: assert property (
    train_sel != 2'h3 |=> train_word == $past(builtin_word)) else $error("bad builtin");
  clip_gain_a: assert property (
    (reg_wr && reg_addr == 8'h14) |-> ##2 {auto_gain_active, gain_a, gain_b} ==
    ($past(reg_wdata[7], 2) ? {1'b0, $past(reg_wdata[5:0], 2)} : 7'h40))
    else $error("bad gain");
endmodule
bind training_pattern_gain_regs regs_checker regs_checker_inst (.core_clk, .rst, .reg_wr,
  .reg_rd, .reg_rvalid, .auto_gain_active, .reg_addr, .reg_wdata, .reg_rdata, .train_sel,
  .builtin_word, .train_word, .gain_a, .gain_b);

// ==== verification/host.sv ====
/* serial control host issuing one register access per call.
   assumes strobes are sampled on the rising edge of core_clk. */
`timescale 1ns/1ns
module host (
  input  logic       core_clk,
  output logic       reg_wr = 1'b0,
  output logic       reg_rd = 1'b0,
  output logic [7:0] reg_addr = 8'h00,
  output logic [7:0] reg_wdata = 8'h00
);
  // idle lines show inverted values so stale data never looks valid
  task automatic op(input logic w, r, input logic [7:0] a, d);
    @(posedge core_clk);
    #1;
    reg_wr = w;
    reg_rd = r;
    reg_addr = (w | r) ? a : ~reg_addr;
    reg_wdata = w ? ((a == 8'h12) ? {4'h0, d[3:0]} : d) : ~reg_wdata;
  endtask
endmodule

// ==== verification/tb_training_pattern_gain_regs.sv ====
/* self-checking bench for the pattern and clip gain bank.
   assumes the host model makes every register access. */
`timescale 1ns/1ns
module tb_training_pattern_gain_regs;
  logic        core_clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, reg_rvalid, auto_gain_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  train_sel = 2'h3;
  logic [11:0] builtin_word = 12'h123, train_word;
  logic [2:0]  gain_a, gain_b;
  int          num_errors = 0, compares = 0;
  // write addr, data, read addr, expected; 33h is unmapped
  logic [31:0] rows [6] = '{32'h10a511a5, 32'h120c130c, 32'h14ad15ad, 32'h142b152b,
                            32'h33ff1000, 32'h105a130c};
  always #2 core_clk = ~core_clk;
  training_pattern_gain_regs training_pattern_gain_regs_inst (.core_clk, .rst, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .train_sel, .builtin_word, .reg_rdata, .reg_rvalid,
    .train_word, .auto_gain_active, .gain_a, .gain_b);
  host host_inst (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  task automatic chk(input string nm, input logic [11:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // read, then one idle cycle so the registered answer lands
  task automatic rd_chk(input logic [7:0] a, exp);
    host_inst.op(1'b0, 1'b1, a, 8'h00);
    host_inst.op(1'b0, 1'b0, 8'h00, 8'h00);
    chk("rdata", {4'h0, reg_rdata}, {4'h0, exp});
    chk("rvalid", {11'h0, reg_rvalid}, 12'h001);
  endtask
  // flag and both coefficients in one go
  task automatic gain_chk(input logic au, input logic [2:0] ga, gb);
    chk("auto", {11'h0, auto_gain_active}, {11'h0, au});
    chk("gain_a", {9'h0, gain_a}, {9'h0, ga});
    chk("gain_b", {9'h0, gain_b}, {9'h0, gb});
  endtask
  task automatic close_out;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    rd_chk(8'h15, 8'h00);
    gain_chk(1'b1, 3'h0, 3'h0);
    foreach (rows[i])
    begin
      host_inst.op(1'b1, 1'b0, rows[i][31:24], rows[i][23:16]);
      rd_chk(rows[i][15:8], rows[i][7:0]);
    end
    chk("word", train_word, 12'hc5a);
    gain_chk(1'b1, 3'h0, 3'h0);
    train_sel = 2'h0;
    host_inst.op(1'b0, 1'b0, 8'h00, 8'h00);
    chk("word", train_word, 12'h123);
    // override set: coefficients a=5 and b=5 come from the register
    host_inst.op(1'b1, 1'b0, 8'h14, 8'had);
    rd_chk(8'h15, 8'had);
    gain_chk(1'b0, 3'h5, 3'h5);
    rst = 1'b1;
    #4 rst = 1'b0;
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h15, 8'h00);
    gain_chk(1'b1, 3'h0, 3'h0);
    close_out;
  end
  // whole run is under 100 cycles
  initial
  begin
    #2000;
    num_errors++;
    close_out;
  end
endmodule
